/* shared/adcp_pkg.sv */
/*
 * adcp_pkg: constants shared by the converter end and the capture end.
 * assumes a single 100 MHz system clock at both ends.
 */
package adcp_pkg;
    // system clock
    localparam int ADCP_CLK_PERIOD_NS = 10;
    // sample path
    localparam int ADCP_DATA_W = 14;
    localparam int ADCP_LAT_CYC = 12;
    localparam int ADCP_DIV_W = 3;
    localparam int ADCP_DLY_W = 5;
    localparam int ADCP_DLY_TAPS = 32;
    // wake-up after power-down
    localparam int ADCP_WAKE_US = 500;
    localparam int ADCP_WAKE_CYC = ADCP_WAKE_US * 1000 / ADCP_CLK_PERIOD_NS;
    // serial port timing, least serial clock period and high time
    localparam int ADCP_SCLK_PERIOD_NS = 40;
    localparam int ADCP_SCLK_HIGH_NS = 10;
    localparam int ADCP_SCLK_HALF_CYC =
        (ADCP_SCLK_PERIOD_NS / 2 + ADCP_CLK_PERIOD_NS - 1) / ADCP_CLK_PERIOD_NS;
    // serial frame: rw bit, 7 address bits, 8 data bits
    localparam int ADCP_FRAME_BITS = 16;
    localparam int ADCP_HDR_BITS = 8;
    // converter registers, reached over the serial port
    localparam logic [6:0] ADCP_REG_POWER = 7'h08;
    localparam logic [6:0] ADCP_REG_CLKDIV = 7'h0b;
    localparam logic [6:0] ADCP_REG_OUTMODE = 7'h14;
    localparam logic [6:0] ADCP_REG_DCO_DLY = 7'h17;
    localparam int ADCP_PD_BIT = 0;
    localparam int ADCP_LVDS_BIT = 0;
    localparam logic [2:0] ADCP_CLKDIV_RST = 3'h1;
    localparam logic [4:0] ADCP_DCO_DLY_RST = 5'h00;
    // capture controller registers, reached over the plain command port
    localparam logic [7:0] ADCP_HREG_CMD = 8'h00;
    localparam logic [7:0] ADCP_HREG_WDATA = 8'h04;
    localparam logic [7:0] ADCP_HREG_RDATA = 8'h08;
    localparam logic [7:0] ADCP_HREG_STATUS = 8'h0c;
    localparam logic [7:0] ADCP_HREG_CTRL = 8'h10;
    localparam int ADCP_CMD_RW_BIT = 8;
    localparam int ADCP_ST_BUSY_BIT = 0;
    localparam int ADCP_ST_LIVE_BIT = 1;
    localparam int ADCP_CTRL_LVDS_BIT = 0;
    localparam int ADCP_CTRL_SYNC_BIT = 1;
endpackage

/* shared/adcp_link_if.sv */
/*
 * adcp_link_if: pins between the converter and its capture logic.
 * assumes both ends run on the same system clock; the shared data pin
 * idles high through a pull-up.
 */
`timescale 1ns/1ps
`default_nettype none
interface adcp_link_if;
    import adcp_pkg::*;
    logic [ADCP_DATA_W-1:0] data_a;
    logic [ADCP_DATA_W-1:0] data_b;
    logic forwarded_data_clock;
    logic sync;
    logic sclk;
    logic serial_select_n;
    logic sdio_dev_o;
    logic sdio_dev_oe;
    logic sdio_host_o;
    logic sdio_host_oe;
    wire logic sdio;

    // pull-up when nobody drives
    assign sdio = sdio_dev_oe ? sdio_dev_o : (sdio_host_oe ? sdio_host_o : 1'b1);

    modport dev (
        output data_a, data_b, forwarded_data_clock, sdio_dev_o, sdio_dev_oe,
        input sync, sclk, serial_select_n, sdio
    );
    modport host (
        input data_a, data_b, forwarded_data_clock, sdio,
        output sync, sclk, serial_select_n, sdio_host_o, sdio_host_oe
    );
endinterface
`default_nettype wire

/* hw/adcp_dev.sv */
/*
 * adcp_dev: digital timing model of the dual converter: clock divider,
 * sample pipeline, output modes, forwarded clock delay, wake-up and the
 * serial control port.
 * assumes the link pins are synchronous to sys_clk_in and that the
 * serial clock comes from the capture end, slower than the system clock.
 */
`timescale 1ns/1ps
`default_nettype none

// How it works
// - conversions run at divided clock rate
// - cmos mode word appears twelve cycles later
// - lvds channel a at 12, b at 12.5
// - output invalid for 500 us after wake
// - five-bit field delays forwarded clock
// - sync sampled on rising clock edge
// - serial bits captured on rising serial clock
// - read turns data pin out on falling edge
// - read releases data pin on rising edge
module adcp_dev
    import adcp_pkg::*;
#(
    parameter int WAKE_CYC = ADCP_WAKE_CYC
) (
    input wire logic sys_clk_in,
    input wire logic arst_n_in,
    adcp_link_if.dev link,
    input wire logic [ADCP_DATA_W-1:0] ch_a_in,
    input wire logic [ADCP_DATA_W-1:0] ch_b_in,
    output logic awake_out
);
    typedef logic [ADCP_DATA_W-1:0] adcp_word_type;

    // configuration registers
    logic pd_r;
    logic lvds_r;
    logic [ADCP_DIV_W-1:0] div_m1_r;
    logic [ADCP_DLY_W-1:0] dly_r;

    // serial port state
    logic sclk_q_r;
    logic [ADCP_FRAME_BITS-1:0] sh_r;
    logic [4:0] bit_r;
    logic rd_r;
    logic [6:0] addr_r;
    logic [7:0] tx_r;
    logic oe_r;
    logic sclk_rise;
    logic sclk_fall;
    logic wr_now;

    // conversion timing
    logic [31:0] wake_r;
    logic run;
    logic sync_q_r;
    logic sync_prev_r;
    logic [ADCP_DIV_W-1:0] ph_r;
    logic [ADCP_DIV_W-1:0] ph_nxt;
    logic [ADCP_DIV_W-1:0] half;
    logic tick;
    adcp_word_type pa_r [ADCP_LAT_CYC];
    adcp_word_type pb_r [ADCP_LAT_CYC];
    adcp_word_type out_a_r;
    adcp_word_type out_b_r;
    logic [ADCP_DLY_TAPS:0] fdc_r;

    function automatic logic [7:0] reg_read(input logic [6:0] a);
        logic [7:0] v;
        v = 8'h00;
        unique case (a)
            ADCP_REG_POWER: v[ADCP_PD_BIT] = pd_r;
            ADCP_REG_CLKDIV: v[ADCP_DIV_W-1:0] = div_m1_r;
            ADCP_REG_OUTMODE: v[ADCP_LVDS_BIT] = lvds_r;
            ADCP_REG_DCO_DLY: v[ADCP_DLY_W-1:0] = dly_r;
            default: v = 8'h00;
        endcase
        return v;
    endfunction

    // the serial clock is slow and synchronous, so a one-cycle edge
    // detector is enough; the device acts one system cycle after the edge
    assign sclk_rise = link.sclk & ~sclk_q_r & ~link.serial_select_n;
    assign sclk_fall = ~link.sclk & sclk_q_r & ~link.serial_select_n;
    assign wr_now = sclk_rise && (bit_r == 5'(ADCP_FRAME_BITS - 1)) && !rd_r;

    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            sclk_q_r <= 1'b0;
        end else begin
            sclk_q_r <= link.sclk;
        end
    end

    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            sh_r <= '0;
            bit_r <= '0;
            rd_r <= 1'b0;
            addr_r <= '0;
        end else if (link.serial_select_n) begin
            bit_r <= '0;
            rd_r <= 1'b0;
        end else if (sclk_rise) begin
            sh_r <= {sh_r[ADCP_FRAME_BITS-2:0], link.sdio};
            bit_r <= bit_r + 5'h01;
            if (bit_r == 5'(ADCP_HDR_BITS - 1)) begin
                rd_r <= sh_r[ADCP_HDR_BITS-2];
                addr_r <= {sh_r[5:0], link.sdio};
            end
        end
    end

    // read turnaround: drive from the first fall after the header and
    // let go at the rise that ends the last data bit
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            oe_r <= 1'b0;
            tx_r <= '0;
        end else if (link.serial_select_n) begin
            oe_r <= 1'b0;
        end else if (sclk_rise && bit_r == 5'(ADCP_FRAME_BITS - 1)) begin
            oe_r <= 1'b0;
        end else if (sclk_fall && rd_r) begin
            if (!oe_r && bit_r == 5'(ADCP_HDR_BITS)) begin
                oe_r <= 1'b1;
                tx_r <= reg_read(addr_r);
            end else if (oe_r) begin
                tx_r <= {tx_r[6:0], 1'b0};
            end
        end
    end

    assign link.sdio_dev_oe = oe_r;
    assign link.sdio_dev_o = tx_r[7];

    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            pd_r <= 1'b0;
            lvds_r <= 1'b0;
            div_m1_r <= ADCP_CLKDIV_RST;
            dly_r <= ADCP_DCO_DLY_RST;
        end else if (wr_now) begin
            unique case (addr_r)
                ADCP_REG_POWER: pd_r <= link.sdio;
                ADCP_REG_CLKDIV: div_m1_r <= {sh_r[1:0], link.sdio};
                ADCP_REG_OUTMODE: lvds_r <= link.sdio;
                ADCP_REG_DCO_DLY: dly_r <= {sh_r[3:0], link.sdio};
                default: ;
            endcase
        end
    end

    // wake counter reloads while powered down and runs out after release
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            wake_r <= '0;
        end else if (pd_r) begin
            wake_r <= 32'(WAKE_CYC);
        end else if (wake_r != '0) begin
            wake_r <= wake_r - 32'h1;
        end
    end

    assign run = !pd_r && (wake_r == '0);

    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            awake_out <= 1'b0;
        end else begin
            awake_out <= run;
        end
    end

    // sync is taken only at the rising system clock edge; a rising sync
    // restarts the divider so several converters share a phase
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            sync_q_r <= 1'b0;
            sync_prev_r <= 1'b0;
        end else begin
            sync_q_r <= link.sync;
            sync_prev_r <= sync_q_r;
        end
    end

    assign tick = run && (ph_r == div_m1_r);
    assign half = 3'((4'(div_m1_r) + 4'h2) >> 1);

    always_comb begin
        if (!run || (sync_q_r && !sync_prev_r)) begin
            ph_nxt = '0;
        end else if (tick) begin
            ph_nxt = '0;
        end else begin
            ph_nxt = ph_r + 3'h1;
        end
    end

    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            ph_r <= '0;
        end else begin
            ph_r <= ph_nxt;
        end
    end

    // pipeline advances only on the divided clock
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            for (int i = 0; i < ADCP_LAT_CYC; i++) begin
                pa_r[i] <= '0;
                pb_r[i] <= '0;
            end
        end else if (tick) begin
            pa_r[0] <= ch_a_in;
            pb_r[0] <= ch_b_in;
            for (int i = 1; i < ADCP_LAT_CYC; i++) begin
                pa_r[i] <= pa_r[i-1];
                pb_r[i] <= pb_r[i-1];
            end
        end
    end

    // lvds shares one bus: a from the tick, b from mid-period; needs a
    // divide ratio of two or more, otherwise b is never shown
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            out_a_r <= '0;
            out_b_r <= '0;
        end else if (!run) begin
            out_a_r <= '0;
            out_b_r <= '0;
        end else if (tick) begin
            out_a_r <= pa_r[ADCP_LAT_CYC-1];
            out_b_r <= pb_r[ADCP_LAT_CYC-1];
        end else if (lvds_r && ph_nxt == half) begin
            out_a_r <= out_b_r;
        end
    end

    assign link.data_a = out_a_r;
    assign link.data_b = lvds_r ? '0 : out_b_r;

    // forwarded clock: high in the first half of each conversion period,
    // then through a tapped delay line of system cycles
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            fdc_r <= '0;
        end else begin
            fdc_r <= {fdc_r[ADCP_DLY_TAPS-1:0], run && (ph_nxt < half)};
        end
    end

    assign link.forwarded_data_clock = fdc_r[dly_r];
endmodule // adcp_dev
`default_nettype wire

/* hw/adcp_host.sv */
/*
 * adcp_host: capture controller for the converter: serial port master,
 * sync driver and sample capture on the forwarded clock.
 * assumes a software master on the plain command port and the converter
 * end on the link, both on sys_clk_in.
 */
`timescale 1ns/1ps
`default_nettype none
module adcp_host
    import adcp_pkg::*;
#(
    parameter int WAKE_CYC = ADCP_WAKE_CYC
) (
    input wire logic sys_clk_in,
    input wire logic arst_n_in,
    adcp_link_if.host link,
    input wire logic [7:0] addr_in,
    input wire logic [31:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [31:0] rdata_out,
    output logic [ADCP_DATA_W-1:0] sample_a_out,
    output logic [ADCP_DATA_W-1:0] sample_b_out,
    output logic sample_valid_out
);
    typedef enum logic [1:0] {ST_IDLE, ST_LOW, ST_HIGH, ST_TAIL} adcp_state_type;

    adcp_state_type st_r;
    logic [ADCP_FRAME_BITS-1:0] frame_r;
    logic [7:0] wdat_r;
    logic [7:0] rx_r;
    logic [4:0] bit_r;
    logic [1:0] cnt_r;
    logic sclk_r;
    logic sel_n_r;
    logic oe_r;
    logic rw_r;
    logic lvds_r;
    logic sync_r;
    logic [31:0] wake_r;
    logic pd_r;
    logic fdc_q_r;
    logic half_done;
    logic start;
    logic live;

    assign half_done = (cnt_r == 2'(ADCP_SCLK_HALF_CYC - 1));
    assign start = wr_in && addr_in == ADCP_HREG_CMD && st_r == ST_IDLE;
    assign live = !pd_r && wake_r == '0;

    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            wdat_r <= '0;
            lvds_r <= 1'b0;
            sync_r <= 1'b0;
        end else if (wr_in && addr_in == ADCP_HREG_WDATA) begin
            wdat_r <= wdata_in[7:0];
        end else if (wr_in && addr_in == ADCP_HREG_CTRL) begin
            lvds_r <= wdata_in[ADCP_CTRL_LVDS_BIT];
            sync_r <= wdata_in[ADCP_CTRL_SYNC_BIT];
        end
    end

    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rdata_out <= '0;
        end else if (rd_in) begin
            unique case (addr_in)
                ADCP_HREG_RDATA: rdata_out <= {24'h000000, rx_r};
                ADCP_HREG_STATUS: rdata_out <= {30'h0, live, st_r != ST_IDLE};
                ADCP_HREG_CTRL: rdata_out <= {30'h0, sync_r, lvds_r};
                default: rdata_out <= '0;
            endcase
        end else begin
            rdata_out <= '0;
        end
    end

    // serial master: data changes with sclk low, device takes it on the rise
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            st_r <= ST_IDLE;
            frame_r <= '0;
            rx_r <= '0;
            bit_r <= '0;
            cnt_r <= '0;
            sclk_r <= 1'b0;
            sel_n_r <= 1'b1;
            oe_r <= 1'b0;
            rw_r <= 1'b0;
        end else begin
            cnt_r <= half_done ? 2'h0 : cnt_r + 2'h1;
            unique case (st_r)
                ST_IDLE: begin
                    cnt_r <= '0;
                    if (start) begin
                        frame_r <= {wdata_in[ADCP_CMD_RW_BIT], wdata_in[6:0], wdat_r};
                        // the rw bit is shifted out early, so keep it for turnaround
                        rw_r <= wdata_in[ADCP_CMD_RW_BIT];
                        sel_n_r <= 1'b0;
                        oe_r <= 1'b1;
                        bit_r <= '0;
                        st_r <= ST_LOW;
                    end
                end
                ST_LOW: if (half_done) begin
                    sclk_r <= 1'b1;
                    if (bit_r >= 5'(ADCP_HDR_BITS)) begin
                        rx_r <= {rx_r[6:0], link.sdio};
                    end
                    st_r <= ST_HIGH;
                end
                ST_HIGH: if (half_done) begin
                    sclk_r <= 1'b0;
                    frame_r <= {frame_r[ADCP_FRAME_BITS-2:0], 1'b0};
                    bit_r <= bit_r + 5'h01;
                    // stay off the pin through the read data phase
                    if (bit_r == 5'(ADCP_HDR_BITS - 1) && rw_r) begin
                        oe_r <= 1'b0;
                    end
                    st_r <= (bit_r == 5'(ADCP_FRAME_BITS - 1)) ? ST_TAIL : ST_LOW;
                end
                ST_TAIL: if (half_done) begin
                    sel_n_r <= 1'b1;
                    oe_r <= 1'b0;
                    st_r <= ST_IDLE;
                end
            endcase
        end
    end

    assign link.sclk = sclk_r;
    assign link.serial_select_n = sel_n_r;
    assign link.sdio_host_oe = oe_r;
    assign link.sdio_host_o = frame_r[ADCP_FRAME_BITS-1];
    assign link.sync = sync_r;

    // power writes are snooped so captures are dropped during wake-up
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            pd_r <= 1'b0;
            wake_r <= '0;
        end else begin
            if (start && wdata_in[6:0] == ADCP_REG_POWER && !wdata_in[ADCP_CMD_RW_BIT]) begin
                pd_r <= wdat_r[ADCP_PD_BIT];
                wake_r <= 32'(WAKE_CYC);
            end else if (wake_r != '0) begin
                wake_r <= wake_r - 32'h1;
            end
        end
    end

    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            fdc_q_r <= 1'b0;
            sample_a_out <= '0;
            sample_b_out <= '0;
            sample_valid_out <= 1'b0;
        end else begin
            fdc_q_r <= link.forwarded_data_clock;
            sample_valid_out <= 1'b0;
            if (link.forwarded_data_clock && !fdc_q_r) begin
                sample_a_out <= link.data_a;
                if (!lvds_r) begin
                    sample_b_out <= link.data_b;
                    sample_valid_out <= live;
                end
            end else if (!link.forwarded_data_clock && fdc_q_r && lvds_r) begin
                sample_b_out <= link.data_a;
                sample_valid_out <= live;
            end
        end
    end
endmodule // adcp_host
`default_nettype wire

/* test/adcp_link_checker.sv */
/*
 * adcp_link_checker: timing checks on the serial port pins of the link.
 * assumes it watches the one interface joining the two design ends.
 */
`timescale 1ns/1ps
`default_nettype none
module adcp_link_checker
    import adcp_pkg::*;
(
    input wire logic sys_clk_in,
    input wire logic arst_n_in,
    input wire logic sclk,
    input wire logic serial_select_n,
    input wire logic sdio_dev_oe,
    input wire logic sdio_host_o,
    input wire logic sdio_host_oe
);
    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (!arst_n_in);

    a_no_contention: assert property (!(sdio_dev_oe && sdio_host_oe))
        else $error("both ends drive the data pin");
    a_turn_on_fall: assert property ($rose(sdio_dev_oe) |-> !sclk && $past(sclk, 2)
        && !$past(sdio_host_oe)) else $error("device drive not after a serial clock fall");
    a_release_rise: assert property ($fell(sdio_dev_oe) |-> sclk && $past(sclk))
        else $error("device release not after a serial clock rise");
    a_drive_span: assert property ($rose(sdio_dev_oe) |->
        sdio_dev_oe [*8] ##[20:24] !sdio_dev_oe) else $error("read drive span wrong");
    a_drive_selected: assert property (sdio_dev_oe |-> !serial_select_n)
        else $error("device drives while not selected");
    a_bit_stable: assert property ($rose(sclk) && sdio_host_oe |->
        $stable(sdio_host_o) ##1 $stable(sdio_host_o)) else $error("bit moves at clock rise");
    a_clock_high: assert property ($rose(sclk) |=> sclk ##1 !sclk)
        else $error("serial clock high time wrong");
    a_idle_low: assert property (serial_select_n |-> !sclk)
        else $error("serial clock moves outside a frame");
endmodule // adcp_link_checker
`default_nettype wire

/* test/test_adcp.sv */
/*
 * test_adcp: converter end and capture end joined by the link; software
 * commands go through the plain port of the capture end.
 * assumes one 100 MHz clock and a short wake-up count for simulation.
 */
`timescale 1ns/1ps
`default_nettype none
module test_adcp
    import adcp_pkg::*;
;
    // wake count kept short, long enough to see the discard interval
    localparam int WAKE = 100;
    localparam int LIMIT = 20000;
    logic sys_clk_in;
    logic arst_n_in;
    logic [7:0] addr_in;
    logic [31:0] wdata_in;
    logic wr_in;
    logic rd_in;
    logic [31:0] rdata_out;
    logic [ADCP_DATA_W-1:0] ch_a_in, ch_b_in, a_set, b_set, sample_a, sample_b;
    logic sample_valid, awake, free_run;
    logic [31:0] got;
    int errors, cmp_count, cycles, n;
    time ts, off [2];
    wire logic fdc;

    adcp_link_if adcp_link_if_i ();
    assign fdc = adcp_link_if_i.forwarded_data_clock;

    adcp_dev #(.WAKE_CYC(WAKE)) adcp_dev_i (.sys_clk_in(sys_clk_in), .arst_n_in(arst_n_in),
        .link(adcp_link_if_i), .ch_a_in(ch_a_in), .ch_b_in(ch_b_in), .awake_out(awake));
    adcp_host #(.WAKE_CYC(WAKE)) adcp_host_i (.sys_clk_in(sys_clk_in),
        .arst_n_in(arst_n_in), .link(adcp_link_if_i), .addr_in(addr_in),
        .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
        .sample_a_out(sample_a), .sample_b_out(sample_b), .sample_valid_out(sample_valid));
    adcp_link_checker adcp_link_checker_i (.sys_clk_in(sys_clk_in), .arst_n_in(arst_n_in),
        .sclk(adcp_link_if_i.sclk), .serial_select_n(adcp_link_if_i.serial_select_n),
        .sdio_dev_oe(adcp_link_if_i.sdio_dev_oe), .sdio_host_o(adcp_link_if_i.sdio_host_o),
        .sdio_host_oe(adcp_link_if_i.sdio_host_oe));

    initial begin
        sys_clk_in = 1'b0;
        forever #5 sys_clk_in = ~sys_clk_in;
    end

    // counting input on channel a makes every channel a conversion word distinct
    always @(posedge sys_clk_in) begin
        ch_a_in <= free_run ? ch_a_in + 14'h0001 : a_set;
        ch_b_in <= b_set;
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            errors++;
            results();
        end
    end

    task automatic results();
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // an idle edge always passes before the next strobe
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk_in);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1'b1;
        @(posedge sys_clk_in);
        wr_in <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge sys_clk_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge sys_clk_in);
        rd_in <= 1'b0;
        @(posedge sys_clk_in);
        got = rdata_out;
    endtask

    task automatic spi(input logic rw, input logic [6:0] a, input logic [7:0] d);
        wr(ADCP_HREG_WDATA, {24'h000000, d});
        wr(ADCP_HREG_CMD, {23'h000000, rw, 1'b0, a});
        n = 0;
        do begin
            rd(ADCP_HREG_STATUS);
            n++;
        end while (got[ADCP_ST_BUSY_BIT] !== 1'b0 && n < 100);
        check("serial busy", 32'h0, 32'(got[ADCP_ST_BUSY_BIT]));
    endtask

    task automatic dev_rd(input logic [6:0] a, input logic [7:0] exp, input string what);
        spi(1'b1, a, 8'h00);
        rd(ADCP_HREG_RDATA);
        check(what, {24'h000000, exp}, got);
    endtask

    task automatic rises(input int k);
        repeat (k) @(posedge fdc);
        @(negedge sys_clk_in);
    endtask

    initial begin
        arst_n_in = 1'b0;
        addr_in = 8'h00;
        wdata_in = 32'h0;
        wr_in = 1'b0;
        rd_in = 1'b0;
        free_run = 1'b0;
        a_set = 14'h0000;
        b_set = 14'h0000;
        errors = 0;
        cmp_count = 0;
        cycles = 0;
        repeat (8) @(posedge sys_clk_in);
        arst_n_in <= 1'b1;
        dev_rd(ADCP_REG_CLKDIV, 8'(ADCP_CLKDIV_RST), "divider reset");
        dev_rd(ADCP_REG_DCO_DLY, 8'(ADCP_DCO_DLY_RST), "delay reset");
        dev_rd(7'h33, 8'h00, "unmapped device reg");
        rd(8'h20);
        check("unmapped host reg", 32'h0, got);
        $display("test reset values done");
        for (int f = 1; f < 8; f++) begin
            spi(1'b0, ADCP_REG_CLKDIV, 8'(f));
            dev_rd(ADCP_REG_CLKDIV, 8'(f), "divider readback");
            @(posedge fdc);
            ts = $time;
            @(posedge fdc);
            check("conversion period", 32'((f + 1) * 10), 32'($time - ts));
        end
        $display("test divider done");
        spi(1'b0, ADCP_REG_CLKDIV, 8'h03);
        a_set <= 14'h0123;
        b_set <= 14'h0456;
        rises(16);
        @(posedge fdc);
        a_set <= 14'h2abc;
        b_set <= 14'h1def;
        rises(12);
        check("cmos a old", 32'h0123, 32'(adcp_link_if_i.data_a));
        rises(1);
        check("cmos a new", 32'h2abc, 32'(adcp_link_if_i.data_a));
        check("cmos b new", 32'h1def, 32'(adcp_link_if_i.data_b));
        repeat (3) @(posedge sys_clk_in);
        check("capture a", 32'h2abc, 32'(sample_a));
        check("capture b", 32'h1def, 32'(sample_b));
        $display("test cmos latency done");
        spi(1'b0, ADCP_REG_OUTMODE, 8'h01);
        wr(ADCP_HREG_CTRL, 32'h1);
        a_set <= 14'h1357;
        b_set <= 14'h2468;
        rises(14);
        check("lvds first half", 32'h1357, 32'(adcp_link_if_i.data_a));
        check("lvds second bus", 32'h0, 32'(adcp_link_if_i.data_b));
        @(negedge fdc);
        @(negedge sys_clk_in);
        check("lvds second half", 32'h2468, 32'(adcp_link_if_i.data_a));
        @(posedge sys_clk_in iff sample_valid);
        @(negedge sys_clk_in);
        check("lvds capture a", 32'h1357, 32'(sample_a));
        check("lvds capture b", 32'h2468, 32'(sample_b));
        spi(1'b0, ADCP_REG_OUTMODE, 8'h00);
        wr(ADCP_HREG_CTRL, 32'h0);
        $display("test lvds done");
        spi(1'b0, ADCP_REG_CLKDIV, 8'h07);
        spi(1'b0, ADCP_REG_DCO_DLY, 8'h1f);
        dev_rd(ADCP_REG_DCO_DLY, 8'h1f, "delay readback");
        free_run <= 1'b1;
        for (int d = 0; d < 4; d += 3) begin
            spi(1'b0, ADCP_REG_DCO_DLY, 8'(d));
            rises(2);
            @(adcp_link_if_i.data_a);
            #1;
            n = 0;
            while (fdc !== 1'b1 && n < 40) begin
                @(posedge sys_clk_in);
                #1;
                n++;
            end
            check("clock delay", 32'(d), 32'(n));
        end
        spi(1'b0, ADCP_REG_DCO_DLY, 8'h00);
        free_run <= 1'b0;
        $display("test clock delay done");
        for (int k = 0; k < 2; k++) begin
            repeat (k * 3 + 1) @(posedge sys_clk_in);
            wr(ADCP_HREG_CTRL, 32'h2);
            @(posedge adcp_link_if_i.sync);
            ts = $time;
            repeat (12) @(posedge sys_clk_in);
            @(posedge fdc);
            off[k] = ($time - ts) % 80;
            wr(ADCP_HREG_CTRL, 32'h0);
        end
        check("sync alignment", 32'(off[0]), 32'(off[1]));
        $display("test sync done");
        spi(1'b0, ADCP_REG_POWER, 8'h01);
        rd(ADCP_HREG_STATUS);
        check("live when down", 32'h0, 32'(got[ADCP_ST_LIVE_BIT]));
        @(negedge sys_clk_in);
        check("awake when down", 32'h0, 32'(awake));
        check("data when down", 32'h0, 32'(adcp_link_if_i.data_a));
        spi(1'b0, ADCP_REG_POWER, 8'h00);
        repeat (WAKE - 40) @(posedge sys_clk_in);
        @(negedge sys_clk_in);
        check("awake too early", 32'h0, 32'(awake));
        repeat (50) @(posedge sys_clk_in);
        @(negedge sys_clk_in);
        check("awake after wait", 32'h1, 32'(awake));
        rd(ADCP_HREG_STATUS);
        check("live after wait", 32'h1, 32'(got[ADCP_ST_LIVE_BIT]));
        $display("test wake-up done");
        results();
    end
endmodule // test_adcp
`default_nettype wire
